// *** logic/fwsr_pkg.sv ***
// package for the flash write-status poll controller
package fwsr_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 8;
  // register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_ADDR = 12'h004;
  localparam logic [11:0] OFS_DATA = 12'h008;
  localparam logic [11:0] OFS_STAT = 12'h00C;
  // control fields
  localparam int CTRL_START = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_ABORT = 2;
  // status fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_RDYPIN = 3;
  localparam int ST_SUSP = 4;
  localparam int ST_BUFAB = 5;
  // status byte bit positions
  localparam int B_POLL = 7;
  localparam int B_ALT = 6;
  localparam int B_LIMIT = 5;
  localparam int B_SECALT = 2;
  localparam int B_BUFAB = 1;
  // reset command byte
  localparam logic [7:0] CMD_RESET = 8'hF0;
  // bus cycle timing
  localparam int CLK_MHZ = 125;
  localparam int STROBE_NS = 80;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
    logic dq_oe;
  } fwsr_pins_t;

  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_RD1 = 7'h02,
    S_RD2 = 7'h04,
    S_CHK = 7'h08,
    S_RECHK = 7'h10,
    S_RST = 7'h20,
    S_FIN = 7'h40
  } fwsr_state_t;
endpackage

// *** logic/fwsr_cycle.sv ***
// one asynchronous flash bus cycle, read or write, with fixed strobe width
`timescale 1ns/10ps
module fwsr_cycle #(
  parameter int STROBE = fwsr_pkg::STROBE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic go,
  input wire logic wr,
  input wire logic [fwsr_pkg::ADDR_W-1:0] addr,
  input wire logic [fwsr_pkg::DATA_W-1:0] wdata,
  input wire logic [fwsr_pkg::DATA_W-1:0] dq_i,
  output fwsr_pkg::fwsr_pins_t pins,
  output logic [fwsr_pkg::DATA_W-1:0] rdata,
  output logic done
);
  logic [7:0] cnt_q;
  logic act_q;
  wire last = (cnt_q == 8'(STROBE));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      act_q <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
      pins <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_o: '0, dq_oe: 1'b0};
    end else if (ce) begin
      done <= 1'b0;
      if (!act_q && go) begin
        act_q <= 1'b1;
        cnt_q <= 8'h01;
        pins <= '{cs_n: 1'b0, oe_n: wr, we_n: !wr, addr: addr, dq_o: wdata, dq_oe: wr};
      end else if (act_q && last) begin
        // strobes rise together; each read is its own framed cycle
        act_q <= 1'b0;
        done <= 1'b1;
        rdata <= dq_i;
        pins.cs_n <= 1'b1;
        pins.oe_n <= 1'b1;
        pins.we_n <= 1'b1;
        pins.dq_oe <= 1'b0;
      end else if (act_q) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule // fwsr_cycle

// *** logic/fwsr_host.sv ***
// host-side status poll controller for an embedded program or erase
`timescale 1ns/10ps
module fwsr_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [fwsr_pkg::DATA_W-1:0] dq_i,
  input wire logic ready_busy_n_pin,
  output fwsr_pkg::fwsr_pins_t flash
);
  fwsr_pkg::fwsr_state_t st_q, st_d;
  logic [fwsr_pkg::ADDR_W-1:0] addr_q;
  logic [fwsr_pkg::DATA_W-1:0] data_q, first_q, last_q;
  logic mode_q, done_q, fail_q, susp_q, bufab_q, rdy_q;
  logic go, wr, cyc_done;
  logic [fwsr_pkg::DATA_W-1:0] cyc_rd;

  // apb decode
  wire acc = psel && penable;
  wire hit_ctrl = (paddr == fwsr_pkg::OFS_CTRL);
  wire hit_addr = (paddr == fwsr_pkg::OFS_ADDR);
  wire hit_data = (paddr == fwsr_pkg::OFS_DATA);
  wire hit_stat = (paddr == fwsr_pkg::OFS_STAT);
  wire hit_any = hit_ctrl || hit_addr || hit_data || hit_stat;
  wire busy = (st_q != fwsr_pkg::S_IDLE);
  wire start = acc && pwrite && hit_ctrl && pwdata[fwsr_pkg::CTRL_START] && !busy;
  wire abort = acc && pwrite && hit_ctrl && pwdata[fwsr_pkg::CTRL_ABORT];
  wire [31:0] stat_word = {26'h0, bufab_q, susp_q, rdy_q, fail_q, done_q, busy};
  wire [31:0] rd_mux = hit_ctrl ? {31'h0, mode_q} :
                       hit_addr ? 32'(addr_q) :
                       hit_data ? {24'h0, last_q} :
                       hit_stat ? stat_word : fwsr_pkg::RD_ZERO;

  // status comparison of two back-to-back reads
  wire alt_moved = first_q[fwsr_pkg::B_ALT] ^ cyc_rd[fwsr_pkg::B_ALT];
  wire sec_moved = first_q[fwsr_pkg::B_SECALT] ^ cyc_rd[fwsr_pkg::B_SECALT];
  wire limit_hi = cyc_rd[fwsr_pkg::B_LIMIT];
  // poll bit: program waits for true datum, erase for 1
  wire poll_ok = mode_q ? cyc_rd[fwsr_pkg::B_POLL] :
                 (cyc_rd[fwsr_pkg::B_POLL] == data_q[fwsr_pkg::B_POLL]);
  wire settled = !alt_moved && poll_ok;

  always_comb begin
    st_d = st_q;
    go = 1'b0;
    wr = 1'b0;
    case (st_q)
      fwsr_pkg::S_IDLE: begin
        if (start) begin
          st_d = fwsr_pkg::S_RD1;
        end
      end
      fwsr_pkg::S_RD1: begin
        go = 1'b1;
        if (cyc_done) begin
          st_d = fwsr_pkg::S_RD2;
        end
      end
      fwsr_pkg::S_RD2: begin
        go = 1'b1;
        if (cyc_done) begin
          if (settled) begin
            st_d = fwsr_pkg::S_FIN;
          end else if (limit_hi) begin
            st_d = fwsr_pkg::S_RECHK;
          end else begin
            st_d = fwsr_pkg::S_CHK;
          end
        end
      end
      fwsr_pkg::S_CHK: begin
        // keep polling; first of a new pair
        st_d = fwsr_pkg::S_RD1;
      end
      fwsr_pkg::S_RECHK: begin
        go = 1'b1;
        if (cyc_done) begin
          st_d = (!(first_q[fwsr_pkg::B_ALT] ^ cyc_rd[fwsr_pkg::B_ALT]) && poll_ok) ?
                 fwsr_pkg::S_FIN : fwsr_pkg::S_RST;
        end
      end
      fwsr_pkg::S_RST: begin
        go = 1'b1;
        wr = 1'b1;
        if (cyc_done) begin
          st_d = fwsr_pkg::S_IDLE;
        end
      end
      fwsr_pkg::S_FIN: begin
        go = 1'b1;
        if (cyc_done) begin
          st_d = fwsr_pkg::S_IDLE;
        end
      end
      default: st_d = fwsr_pkg::S_IDLE;
    endcase
    if (abort) begin
      st_d = fwsr_pkg::S_IDLE;
      go = 1'b0;
    end
  end

  fwsr_cycle u_cyc (
    .pclk(pclk),
    .presetn(presetn),
    .ce(clk_en),
    .go(go && !cyc_done),
    .wr(wr),
    .addr(addr_q),
    .wdata(fwsr_pkg::CMD_RESET),
    .dq_i(dq_i),
    .pins(flash),
    .rdata(cyc_rd),
    .done(cyc_done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= fwsr_pkg::S_IDLE;
      addr_q <= '0;
      data_q <= '0;
      first_q <= '0;
      last_q <= '0;
      mode_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      susp_q <= 1'b0;
      bufab_q <= 1'b0;
      rdy_q <= 1'b0;
      prdata <= fwsr_pkg::RD_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
      rdy_q <= ready_busy_n_pin;
      pready <= psel && !pready;
      pslverr <= psel && !pready && !hit_any;
      prdata <= rd_mux;
      if (acc && pwrite && hit_addr && !busy) begin
        addr_q <= pwdata[fwsr_pkg::ADDR_W-1:0];
      end
      if (acc && pwrite && hit_data && !busy) begin
        data_q <= pwdata[fwsr_pkg::DATA_W-1:0];
      end
      if (start) begin
        mode_q <= pwdata[fwsr_pkg::CTRL_MODE];
        done_q <= 1'b0;
        fail_q <= 1'b0;
        susp_q <= 1'b0;
        bufab_q <= 1'b0;
      end
      if (cyc_done && st_q == fwsr_pkg::S_RD1) begin
        first_q <= cyc_rd;
      end
      if (cyc_done && st_q == fwsr_pkg::S_RD2) begin
        first_q <= cyc_rd;
        bufab_q <= cyc_rd[fwsr_pkg::B_BUFAB];
        // erase: sector bit moving, alternation still = suspend
        susp_q <= mode_q && !alt_moved && sec_moved;
      end
      if (cyc_done && st_q == fwsr_pkg::S_RST) begin
        fail_q <= 1'b1;
        done_q <= 1'b1;
      end
      if (cyc_done && st_q == fwsr_pkg::S_FIN) begin
        last_q <= cyc_rd;
        done_q <= 1'b1;
      end
    end
  end

  // one-cycle access: answer follows setup by one cycle
  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && psel && !penable && !pready) |=> pready)
    else $error("apb answer late");
  // failed recheck, then a real 0xF0 write strobe on the next flash cycle
  sequence fail_seen_s;
    st_q == fwsr_pkg::S_RECHK && cyc_done && st_d == fwsr_pkg::S_RST && clk_en && !abort;
  endsequence
  sequence rst_cmd_s;
    st_q == fwsr_pkg::S_RST ##1
    (!flash.we_n && flash.dq_oe && flash.dq_o == fwsr_pkg::CMD_RESET);
  endsequence
  rst_after_fail_a: assert property (@(posedge pclk) disable iff (!presetn)
    fail_seen_s |=> rst_cmd_s)
    else $error("reset command not issued");
  recheck_limit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == fwsr_pkg::S_RD2 && cyc_done && !settled && limit_hi && clk_en && !abort)
    |=> st_q == fwsr_pkg::S_RECHK)
    else $error("no recheck on limit bit");
  fin_extra_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == fwsr_pkg::S_RD2 && cyc_done && settled && clk_en && !abort)
    |=> st_q == fwsr_pkg::S_FIN)
    else $error("final data not from later read");
  start_polls_a: assert property (@(posedge pclk) disable iff (!presetn)
    (start && clk_en && !abort) |=> st_q == fwsr_pkg::S_RD1)
    else $error("poll not restarted");
  write_only_rst_a: assert property (@(posedge pclk) disable iff (!presetn)
    !flash.we_n |-> flash.dq_o == fwsr_pkg::CMD_RESET)
    else $error("unexpected write data");
  addr_held_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!flash.cs_n && $past(!flash.cs_n)) |-> $stable(flash.addr))
    else $error("address moved in cycle");
  fail_means_rst_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(fail_q) |-> $past(st_q) == fwsr_pkg::S_RST)
    else $error("fail without reset");
endmodule // fwsr_host

// *** test/fwsr_flash_model.sv ***
// behavioural flash device answering status reads
`timescale 1ns/10ps
module fwsr_flash_model (
  input wire logic arm,
  input wire logic [15:0] n_busy,
  input wire logic era,
  input wire logic lim,
  input wire logic sus,
  input wire logic bab,
  input wire logic [7:0] arr,
  input wire fwsr_pkg::fwsr_pins_t pins,
  output logic [7:0] dq,
  output logic rb_n,
  output logic [7:0] last_wr
);
  int left = 0;
  logic stuck = 1'h0, susp = 1'h0, alt = 1'h0, sec = 1'h0, was_wr = 1'h0;
  logic [7:0] val, hold = 8'h00, wd = 8'h00;
  wire rd = !pins.cs_n && !pins.oe_n;
  wire wr = !pins.cs_n && !pins.we_n;
  wire busy = left > 0 || stuck;
  // every selected sector taken as unprotected, so polled status is always valid
  assign val = busy ? {era ? 1'h0 : ~arr[7], alt, stuck, 2'h0, era & sec, bab, 1'h0}
    : susp ? {1'h1, alt, 3'h0, sec, 2'h0} : arr;
  assign rb_n = busy ? 1'h0 : 1'h1;
  // released bus shows the inverse of the last byte
  assign dq = rd ? val : ~hold;
  always @* if (rd) hold = val;
  always @* if (rd || wr) was_wr = wr;
  always @* if (wr) wd = pins.dq_o;
  always @(posedge arm or negedge rd or negedge wr) begin
    if (arm) begin
      left = n_busy;
      stuck = lim;
      susp = sus & era;
    end else if (was_wr) begin
      last_wr = wd;
      if (wd == fwsr_pkg::CMD_RESET) begin
        left = 0;
        stuck = 1'h0;
      end
    end else begin
      if (busy) alt = ~alt;
      sec = sec ^ (era & (busy | susp));
      if (left > 0) left = left - 1;
    end
  end
endmodule // fwsr_flash_model

// *** test/tb_top.sv ***
// self-checking bench for the status poll controller
`timescale 1ns/10ps
module tb_top;
  typedef struct {
    logic e;
    logic l;
    logic s;
    logic [15:0] n;
    logic [7:0] a;
    logic [7:0] m;
    logic [7:0] st;
  } fwsr_row_t;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic arm = 1'h0, era = 1'h0, lim = 1'h0, sus = 1'h0, pready, pslverr, rb_n, err;
  logic bab = 1'h0, ce = 1'h1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [15:0] nb = 16'h0000;
  logic [7:0] arr = 8'h00, dq, last_wr;
  fwsr_pkg::fwsr_pins_t pins, snap;
  int fail_count = 0, checked = 0, cyc = 0;
  fwsr_row_t rows [7] = '{
    '{1'h0, 1'h0, 1'h0, 16'h0000, 8'h3C, 8'h1F, 8'h0A},
    '{1'h0, 1'h0, 1'h0, 16'h0006, 8'hA5, 8'h1F, 8'h0A},
    '{1'h0, 1'h0, 1'h0, 16'h000A, 8'h5A, 8'h1F, 8'h0A},
    '{1'h1, 1'h0, 1'h0, 16'h0008, 8'hFF, 8'h1F, 8'h0A},
    '{1'h1, 1'h0, 1'h0, 16'h03E8, 8'hFF, 8'h1F, 8'h0A},
    '{1'h1, 1'h0, 1'h1, 16'h0000, 8'hFF, 8'h1F, 8'h1A},
    '{1'h0, 1'h1, 1'h0, 16'h0000, 8'h7E, 8'h05, 8'h04}
  };
  fwsr_host dut (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dq_i(dq), .ready_busy_n_pin(rb_n), .flash(pins));
  fwsr_flash_model flash_model (.arm(arm), .n_busy(nb), .era(era), .lim(lim), .sus(sus), .bab(bab),
    .arr(arr), .pins(pins), .dq(dq), .rb_n(rb_n), .last_wr(last_wr));
  always #4 pclk = ~pclk;
  task end_sim();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      end_sim();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      $display("ERROR %0t %s got %h", $time, m, got);
      fail_count++;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task start(input fwsr_row_t r);
    era <= r.e;
    lim <= r.l;
    sus <= r.s;
    nb <= r.n;
    arr <= r.a;
    apb(1'h1, fwsr_pkg::OFS_ADDR, 32'h0000_0100);
    apb(1'h1, fwsr_pkg::OFS_DATA, {24'h0, r.a});
    arm <= 1'h1;
    apb(1'h1, fwsr_pkg::OFS_CTRL, {30'h0, r.e, 1'h1});
    arm <= 1'h0;
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    chk({28'h0, pins.cs_n, pins.oe_n, pins.we_n, pins.dq_oe}, 32'h0000_000E, "reset pins");
    @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, fwsr_pkg::OFS_STAT, 32'h0000_0000);
    chk(rd & 32'h0000_0007, 32'h0000_0000, "reset status");
    apb(1'h0, 12'h010, 32'h0000_0000);
    chk({rd[30:0], err}, 32'h0000_0001, "unmapped read");
    apb(1'h1, 12'h7F0, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h0000_0001, "unmapped write");
    $display("test reset end");
    foreach (rows[i]) begin
      start(rows[i]);
      do apb(1'h0, fwsr_pkg::OFS_STAT, 32'h0000_0000); while (rd[fwsr_pkg::ST_BUSY] === 1'h1);
      chk(rd & {24'h0, rows[i].m}, {24'h0, rows[i].st}, "status");
      if (rows[i].l) begin
        chk({24'h0, last_wr}, {24'h0, fwsr_pkg::CMD_RESET}, "reset command");
      end else if (!rows[i].s) begin
        apb(1'h0, fwsr_pkg::OFS_DATA, 32'h0000_0000);
        chk(rd, {24'h0, rows[i].a}, "array data");
      end
      $display("test %0d end", i);
    end
    bab <= 1'h1;
    start('{1'h0, 1'h0, 1'h0, 16'h07D0, 8'h11, 8'h00, 8'h00});
    for (int k = 0; k < 30; k++) begin
      apb(1'h0, fwsr_pkg::OFS_STAT, 32'h0000_0000);
      if (rd[fwsr_pkg::ST_BUFAB] === 1'h1) break;
    end
    chk(rd & 32'h0000_0029, 32'h0000_0021, "buffer abort busy");
    $display("test buffer abort end");
    do @(posedge pclk); while (pins.cs_n !== 1'h0);
    ce <= 1'h0;
    @(posedge pclk);
    snap = pins;
    repeat (5) @(posedge pclk);
    chk({31'h0, pins !== snap}, 32'h0000_0000, "clock enable freeze");
    ce <= 1'h1;
    $display("test freeze end");
    apb(1'h1, fwsr_pkg::OFS_CTRL, 32'h0000_0004);
    for (int k = 0; k < 30; k++) begin
      apb(1'h0, fwsr_pkg::OFS_STAT, 32'h0000_0000);
      if (rd[fwsr_pkg::ST_BUSY] === 1'h0) break;
    end
    chk({31'h0, rd[fwsr_pkg::ST_BUSY]}, 32'h0000_0000, "abort");
    $display("test abort end");
    end_sim();
  end
endmodule // tb_top
